// >>> core/gms_pkg.sv
// Package of constants and types for the genset mode sequencer.
// Notes on behaviour
// - Panel lock input blocks mode button changes.
// - Load output waits for generator available.
// - Manual mode stays off load without request.
// - Manual loading requests: button, mains, inputs, schedule.
// - Manual/Test load removed only by listed events.
// - Stop/Reset drops load and stops engine immediately.
// - Auto from Manual/Test honours requests and timers.
// - Test mode starts only on Start button.
// - Manual and Test skip the start delay.
// - Failed crank rests, retries, then fail-to-start.
// - Starter released on firing from chosen speed source.
// - Oil pressure may release starter, never speed faults.
// - Safety-on delay masks listed faults after release.
// - Test mode loads generator once available.
// - Test mode open button needs Manual first.
// - Auto start sources: mains, inputs, scheduler, telemetry.
// - Start delay; requests clearing returns to standby.
// - Start delay expiry with request: fuel and crank.
// - Auto loads if configured; no request starts stopping.
// - Return delay; new request during stopping reloads.
// - Return expiry transfers to mains, cool-down, stop.
// - Sixteen schedule entries, two banks, 16/8-day cycles.
package gms_pkg;
    // ------------------------------------------------------------
    // Register map.
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_MODE = 8'h00;
    localparam logic [7:0] ADDR_CFG = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_START_DLY = 8'h0C;
    localparam logic [7:0] ADDR_CRANK = 8'h10;
    localparam logic [7:0] ADDR_REST = 8'h14;
    localparam logic [7:0] ADDR_SAFETY = 8'h18;
    localparam logic [7:0] ADDR_RETURN = 8'h1C;
    localparam logic [7:0] ADDR_COOL = 8'h20;
    localparam logic [7:0] ADDR_ATTEMPTS = 8'h24;
    localparam logic [7:0] ADDR_SCHED = 8'h28;
    localparam logic [7:0] ADDR_ID = 8'h2C;
    // Arbitrary identification value.
    localparam logic [31:0] ID_VALUE = 32'h0000_0A5C;
    // ------------------------------------------------------------
    // Field positions of the configuration register, schedule sizes, reset values and bus transfer codes.
    // ------------------------------------------------------------
    localparam int CFG_AUTO_LOAD = 0;
    localparam int CFG_MPU_EN = 1;
    localparam int CFG_ECU_EN = 2;
    localparam int CFG_OIL_EN = 3;
    localparam int SCHED_ENTRIES = 16;
    localparam int SCHED_BANK = 8;
    localparam logic [31:0] TIMER_RESET = 32'h0000_0064;
    localparam logic [3:0] ATTEMPTS_RESET = 4'h3;
    localparam logic [3:0] CFG_RESET = 4'h1;
    localparam logic [31:0] ZERO32 = 32'h0000_0000;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ = 2'h3;

    typedef enum logic [1:0] {
        GMS_STOP,
        GMS_MANUAL,
        GMS_TEST,
        GMS_AUTO
    } gms_mode_e;

    typedef enum logic [3:0] {
        GMS_IDLE,
        GMS_DELAY,
        GMS_CRANK,
        GMS_REST,
        GMS_SAFETY,
        GMS_RUN,
        GMS_RETURN,
        GMS_COOL,
        GMS_FAIL
    } gms_seq_e;
endpackage

// >>> core/gms_sequencer.sv
// Genset mode and start/stop sequencer with AHB-Lite registers.
//
// Register access over AHB-Lite and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module gms_sequencer (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic btn_stop,
    input wire logic btn_manual,
    input wire logic btn_test,
    input wire logic btn_auto,
    input wire logic btn_start,
    input wire logic btn_to_gen,
    input wire logic btn_to_mains,
    input wire logic panel_lock,
    input wire logic mains_fail,
    input wire logic remote_start,
    input wire logic remote_start_load,
    input wire logic aux_mains_fail,
    input wire logic telemetry_start,
    input wire logic balance_mode,
    input wire logic load_inhibit,
    input wire logic gen_available,
    input wire logic speed_alt,
    input wire logic speed_mpu,
    input wire logic speed_ecu,
    input wire logic oil_rising,
    input wire logic [3:0] day_of_cycle,
    output logic fuel_out,
    output logic starter_out,
    output logic gen_load_out,
    output logic fault_mask,
    output logic fail_to_start,
    output logic [3:0] mode_led
);
    logic [1:0] mode_r;
    logic [3:0] seq_r;
    logic [31:0] tmr_r;
    logic [3:0] tries_r;
    logic loadreq_r;
    logic loaded_r;
    logic man_from_test_r;
    logic [3:0] cfg_r;
    logic [31:0] t_start_r, t_crank_r, t_rest_r, t_safety_r, t_return_r, t_cool_r;
    logic [3:0] attempts_r;
    logic [31:0] sched_r;
    logic sched_onload_r;
    localparam int SYNC_N = 19;
    logic [SYNC_N-1:0] sync_r [0:2];
    logic [SYNC_N-1:0] pins_raw, pins_s;
    logic [7:0] a_addr_r;
    logic a_wr_r;
    logic a_act_r;
    logic s_stop, s_man, s_test, s_auto, s_start, s_gen, s_mains, s_lock;
    logic s_mfail, s_rstart, s_rload, s_aux, s_tele, s_bal, s_inh, s_avail;
    logic s_alt, s_mpu, s_ecu;
    logic [SYNC_N-1:0] pins_q, edge_p;
    logic fired, sched_act, auto_req, manual_loadreq, unload_evt;

    // ------------------------------------------------------------
    // Pin synchronisers, three stages, change taken on agreement.
    // ------------------------------------------------------------
    assign pins_raw = {btn_stop, btn_manual, btn_test, btn_auto, btn_start, btn_to_gen,
        btn_to_mains, panel_lock, mains_fail, remote_start, remote_start_load,
        aux_mains_fail, telemetry_start, balance_mode, load_inhibit, gen_available,
        speed_alt, speed_mpu, speed_ecu};
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync_r[0] <= '0;
            sync_r[1] <= '0;
            sync_r[2] <= '0;
        end else begin
            sync_r[0] <= pins_raw;
            sync_r[1] <= sync_r[0];
            sync_r[2] <= sync_r[1];
        end
    end
    genvar gi;
    generate
        for (gi = 0; gi < SYNC_N; gi++) begin : g_agree
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    pins_s[gi] <= 1'b0;
                end else if (sync_r[1][gi] == sync_r[2][gi]) begin
                    pins_s[gi] <= sync_r[2][gi];
                end
            end
        end
    endgenerate
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pins_q <= '0;
        end else begin
            pins_q <= pins_s;
        end
    end
    assign edge_p = pins_s & ~pins_q;
    assign {s_stop, s_man, s_test, s_auto, s_start, s_gen, s_mains, s_lock} = edge_p[18:11];
    assign {s_mfail, s_rstart, s_rload, s_aux, s_tele, s_bal, s_inh, s_avail} = pins_s[10:3];
    assign {s_alt, s_mpu, s_ecu} = pins_s[2:0];

    // ------------------------------------------------------------
    // Request decoding.
    // ------------------------------------------------------------
    assign sched_act = sched_r[day_of_cycle[3:0]]
        | sched_r[gms_pkg::SCHED_BANK + 32'(day_of_cycle[2:0])];
    assign auto_req = s_mfail | s_rstart | s_aux | sched_act | s_tele | s_bal;
    assign manual_loadreq = s_gen | s_mfail | s_rload | s_aux
        | (sched_act & sched_onload_r) | s_bal;
    assign fired = s_alt | (cfg_r[gms_pkg::CFG_MPU_EN] & s_mpu)
        | (cfg_r[gms_pkg::CFG_ECU_EN] & s_ecu)
        | (cfg_r[gms_pkg::CFG_OIL_EN] & oil_rising);
    // Test mode needs Manual before the open button acts.
    assign unload_evt = (s_mains & (mode_r == 2'(gms_pkg::GMS_MANUAL))) | s_inh;

    // ------------------------------------------------------------
    // Mode selection.
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_r <= 2'(gms_pkg::GMS_STOP);
        end else if (!pins_s[11]) begin
            if (s_stop) begin
                mode_r <= 2'(gms_pkg::GMS_STOP);
            end else if (s_man) begin
                mode_r <= 2'(gms_pkg::GMS_MANUAL);
            end else if (s_test) begin
                mode_r <= 2'(gms_pkg::GMS_TEST);
            end else if (s_auto) begin
                mode_r <= 2'(gms_pkg::GMS_AUTO);
            end
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            man_from_test_r <= 1'b0;
        end else begin
            man_from_test_r <= (mode_r == 2'(gms_pkg::GMS_TEST)) | (man_from_test_r
                & mode_r == 2'(gms_pkg::GMS_MANUAL));
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_led <= 4'h1;
        end else begin
            mode_led <= 4'(1 << mode_r);
        end
    end

    // ------------------------------------------------------------
    // Start and stop sequence.
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            seq_r <= 4'(gms_pkg::GMS_IDLE);
            tmr_r <= gms_pkg::ZERO32;
            tries_r <= 4'h0;
        end else if (mode_r == 2'(gms_pkg::GMS_STOP)) begin
            seq_r <= 4'(gms_pkg::GMS_IDLE);
            tmr_r <= gms_pkg::ZERO32;
            tries_r <= 4'h0;
        end else begin
            tmr_r <= (tmr_r != gms_pkg::ZERO32) ? tmr_r - 32'h0000_0001 : tmr_r;
            unique case (seq_r)
                4'(gms_pkg::GMS_IDLE): begin
                    tries_r <= 4'h0;
                    if (mode_r == 2'(gms_pkg::GMS_AUTO) && auto_req) begin
                        seq_r <= 4'(gms_pkg::GMS_DELAY);
                        tmr_r <= t_start_r;
                    end else if (mode_r != 2'(gms_pkg::GMS_AUTO) && s_start) begin
                        seq_r <= 4'(gms_pkg::GMS_CRANK);
                        tmr_r <= t_crank_r;
                    end
                end
                4'(gms_pkg::GMS_DELAY): begin
                    if (!auto_req) begin
                        seq_r <= 4'(gms_pkg::GMS_IDLE);
                    end else if (tmr_r == gms_pkg::ZERO32) begin
                        seq_r <= 4'(gms_pkg::GMS_CRANK);
                        tmr_r <= t_crank_r;
                    end
                end
                4'(gms_pkg::GMS_CRANK): begin
                    if (fired) begin
                        seq_r <= 4'(gms_pkg::GMS_SAFETY);
                        tmr_r <= t_safety_r;
                    end else if (tmr_r == gms_pkg::ZERO32) begin
                        tries_r <= tries_r + 4'h1;
                        if (tries_r + 4'h1 >= attempts_r) begin
                            seq_r <= 4'(gms_pkg::GMS_FAIL);
                        end else begin
                            seq_r <= 4'(gms_pkg::GMS_REST);
                            tmr_r <= t_rest_r;
                        end
                    end
                end
                4'(gms_pkg::GMS_REST): begin
                    if (tmr_r == gms_pkg::ZERO32) begin
                        seq_r <= 4'(gms_pkg::GMS_CRANK);
                        tmr_r <= t_crank_r;
                    end
                end
                4'(gms_pkg::GMS_SAFETY): begin
                    if (tmr_r == gms_pkg::ZERO32) begin
                        seq_r <= 4'(gms_pkg::GMS_RUN);
                    end
                end
                4'(gms_pkg::GMS_RUN): begin
                    if (mode_r == 2'(gms_pkg::GMS_AUTO) && !auto_req) begin
                        seq_r <= 4'(gms_pkg::GMS_RETURN);
                        tmr_r <= t_return_r;
                    end
                end
                4'(gms_pkg::GMS_RETURN): begin
                    if (auto_req) begin
                        seq_r <= 4'(gms_pkg::GMS_RUN);
                    end else if (tmr_r == gms_pkg::ZERO32) begin
                        seq_r <= 4'(gms_pkg::GMS_COOL);
                        tmr_r <= t_cool_r;
                    end
                end
                4'(gms_pkg::GMS_COOL): begin
                    if (auto_req) begin
                        seq_r <= 4'(gms_pkg::GMS_RUN);
                    end else if (tmr_r == gms_pkg::ZERO32) begin
                        seq_r <= 4'(gms_pkg::GMS_IDLE);
                    end
                end
                4'(gms_pkg::GMS_FAIL): begin
                    seq_r <= seq_r;
                end
                default: begin
                    seq_r <= 4'(gms_pkg::GMS_IDLE);
                end
            endcase
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            loadreq_r <= 1'b0;
        end else if (mode_r == 2'(gms_pkg::GMS_STOP) || mode_r == 2'(gms_pkg::GMS_AUTO)
                || unload_evt) begin
            loadreq_r <= 1'b0;
        end else if (mode_r == 2'(gms_pkg::GMS_TEST) || manual_loadreq) begin
            loadreq_r <= 1'b1;
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            loaded_r <= 1'b0;
        end else begin
            loaded_r <= s_avail && !s_inh && (seq_r == 4'(gms_pkg::GMS_RUN)
                || seq_r == 4'(gms_pkg::GMS_RETURN)) && (mode_r == 2'(gms_pkg::GMS_AUTO)
                ? (cfg_r[gms_pkg::CFG_AUTO_LOAD] | (sched_act & sched_onload_r))
                : loadreq_r);
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fuel_out <= 1'b0;
            starter_out <= 1'b0;
            gen_load_out <= 1'b0;
            fault_mask <= 1'b1;
            fail_to_start <= 1'b0;
        end else begin
            fuel_out <= seq_r != 4'(gms_pkg::GMS_IDLE) && seq_r != 4'(gms_pkg::GMS_DELAY)
                && seq_r != 4'(gms_pkg::GMS_FAIL);
            starter_out <= seq_r == 4'(gms_pkg::GMS_CRANK) && !fired;
            gen_load_out <= loaded_r && mode_r != 2'(gms_pkg::GMS_STOP);
            fault_mask <= seq_r != 4'(gms_pkg::GMS_RUN) && seq_r != 4'(gms_pkg::GMS_RETURN)
                && seq_r != 4'(gms_pkg::GMS_COOL);
            fail_to_start <= seq_r == 4'(gms_pkg::GMS_FAIL);
        end
    end

    // ------------------------------------------------------------
    // AHB-Lite register slave, zero wait states.
    // ------------------------------------------------------------
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            a_act_r <= 1'b0;
            a_wr_r <= 1'b0;
            a_addr_r <= 8'h00;
        end else if (hready) begin
            a_act_r <= hsel && (htrans == gms_pkg::HTRANS_NONSEQ || htrans == gms_pkg::HTRANS_SEQ);
            a_wr_r <= hwrite;
            a_addr_r <= haddr[7:0];
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_r <= gms_pkg::CFG_RESET;
            t_start_r <= gms_pkg::TIMER_RESET;
            t_crank_r <= gms_pkg::TIMER_RESET;
            t_rest_r <= gms_pkg::TIMER_RESET;
            t_safety_r <= gms_pkg::TIMER_RESET;
            t_return_r <= gms_pkg::TIMER_RESET;
            t_cool_r <= gms_pkg::TIMER_RESET;
            attempts_r <= gms_pkg::ATTEMPTS_RESET;
            sched_r <= gms_pkg::ZERO32;
            sched_onload_r <= 1'b0;
        end else if (a_act_r && a_wr_r) begin
            unique case (a_addr_r)
                gms_pkg::ADDR_CFG: cfg_r <= hwdata[3:0];
                gms_pkg::ADDR_START_DLY: t_start_r <= hwdata;
                gms_pkg::ADDR_CRANK: t_crank_r <= hwdata;
                gms_pkg::ADDR_REST: t_rest_r <= hwdata;
                gms_pkg::ADDR_SAFETY: t_safety_r <= hwdata;
                gms_pkg::ADDR_RETURN: t_return_r <= hwdata;
                gms_pkg::ADDR_COOL: t_cool_r <= hwdata;
                gms_pkg::ADDR_ATTEMPTS: attempts_r <= hwdata[3:0];
                gms_pkg::ADDR_SCHED: begin
                    sched_r <= {15'h0000, hwdata[16], hwdata[15:0]};
                    sched_onload_r <= hwdata[16];
                end
                default: begin
                end
            endcase
        end
    end
    always_comb begin
        hrdata = gms_pkg::ZERO32;
        if (a_act_r && !a_wr_r) begin
            unique case (a_addr_r)
                gms_pkg::ADDR_MODE: hrdata = {30'h0000_0000, mode_r};
                gms_pkg::ADDR_CFG: hrdata = {28'h000_0000, cfg_r};
                gms_pkg::ADDR_STATUS: hrdata = {23'h00_0000, fail_to_start, fault_mask,
                    gen_load_out, starter_out, fuel_out, seq_r};
                gms_pkg::ADDR_START_DLY: hrdata = t_start_r;
                gms_pkg::ADDR_CRANK: hrdata = t_crank_r;
                gms_pkg::ADDR_REST: hrdata = t_rest_r;
                gms_pkg::ADDR_SAFETY: hrdata = t_safety_r;
                gms_pkg::ADDR_RETURN: hrdata = t_return_r;
                gms_pkg::ADDR_COOL: hrdata = t_cool_r;
                gms_pkg::ADDR_ATTEMPTS: hrdata = {28'h000_0000, attempts_r};
                gms_pkg::ADDR_SCHED: hrdata = {15'h0000, sched_onload_r, sched_r[15:0]};
                gms_pkg::ADDR_ID: hrdata = gms_pkg::ID_VALUE;
                default: hrdata = gms_pkg::ZERO32;
            endcase
        end
    end
endmodule
`default_nettype wire

// >>> verif/gms_sequencer_properties.sv
// Concurrent checks on the pins of the genset mode sequencer.
`timescale 1ns/1ps
`default_nettype none
module gms_sequencer_checker (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic panel_lock,
    input wire logic load_inhibit,
    input wire logic gen_available,
    input wire logic fuel_out,
    input wire logic starter_out,
    input wire logic gen_load_out,
    input wire logic fault_mask,
    input wire logic fail_to_start,
    input wire logic [3:0] mode_led
);
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    a_led_one_hot: assert property ($onehot(mode_led))
        else $error("mode indicator not one-hot");
    a_lock_holds_mode: assert property (panel_lock [*8] |=> $stable(mode_led))
        else $error("mode changed while panel locked");
    a_load_needs_avail: assert property ($rose(gen_load_out)
        |-> gen_available && $past(gen_available))
        else $error("load closed before generator available");
    a_stop_drops_all: assert property ($rose(mode_led[0])
        |-> ##[0:2] !(fuel_out || starter_out || gen_load_out))
        else $error("stop mode left engine or load on");
    a_crank_has_fuel: assert property (starter_out |-> fuel_out)
        else $error("cranking without fuel");
    a_fail_latched: assert property (fail_to_start && !mode_led[0]
        |=> fail_to_start || mode_led[0])
        else $error("fail-to-start cleared outside stop mode");
    a_fail_engine_off: assert property (fail_to_start |-> !starter_out && !fuel_out)
        else $error("engine driven after fail-to-start");
    a_inhibit_unloads: assert property ((!mode_led[3] && load_inhibit) [*8]
        |-> !gen_load_out)
        else $error("load kept under load inhibit");
    a_mask_at_release: assert property ($fell(starter_out) && fuel_out && !fail_to_start
        |-> fault_mask)
        else $error("faults unmasked at starter release");
endmodule
bind gms_sequencer gms_sequencer_checker u_chk (
    .hclk, .hresetn, .panel_lock, .load_inhibit, .gen_available, .fuel_out, .starter_out,
    .gen_load_out, .fault_mask, .fail_to_start, .mode_led
);
`default_nettype wire

// >>> verif/gms_engine_model.sv
// Behavioural engine and alternator model facing the sequencer.
`timescale 1ns/1ps
`default_nettype none
module gms_engine_model #(
    parameter int FIRE_CYC = 20
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic fuel_out,
    input wire logic starter_out,
    input wire logic fire_en,
    output logic speed_alt,
    output logic speed_mpu,
    output logic speed_ecu,
    output logic oil_rising,
    output logic gen_available
);
    int crank_cnt;
    logic [3:0] run_cnt;
    logic running_r;
    // The engine fires after a spell of cranking with fuel and dies without fuel.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            crank_cnt <= 0;
            run_cnt <= 4'h0;
            running_r <= 1'b0;
        end else begin
            crank_cnt <= (starter_out && fuel_out && !running_r) ? crank_cnt + 1 : 0;
            running_r <= fuel_out && (running_r || (fire_en && crank_cnt >= FIRE_CYC));
            run_cnt <= !running_r ? 4'h0 : (run_cnt == 4'hF) ? run_cnt : run_cnt + 4'h1;
        end
    end
    assign speed_alt = running_r;
    assign speed_mpu = running_r;
    assign speed_ecu = running_r;
    assign oil_rising = running_r;
    assign gen_available = (run_cnt == 4'hF);
endmodule
`default_nettype wire

// >>> verif/tb.sv
// Self-checking bench for the genset mode sequencer.
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [31:0] hrdata, rd;
    logic hreadyout, hresp, speed_alt, speed_mpu, speed_ecu, oil_rising, gen_available;
    logic fuel_out, starter_out, gen_load_out, fault_mask, fail_to_start;
    logic [3:0] mode_led;
    logic [6:0] btn = 7'h00;
    logic [7:0] lvl = 8'h00;
    logic fire_en = 1'b0;
    logic [3:0] day = 4'h0;
    int err_count = 0;
    int tests_run = 0;
    int msrc[4] = '{1, 3, 4, 6};
    int asrc[5] = '{1, 2, 4, 5, 6};
    logic [31:0] tval[7] = '{32'h0000_003C, 32'h0000_001E, 32'h0000_000A, 32'h0000_000A,
                             32'h0000_0028, 32'h0000_0014, 32'h0000_0002};
    wire logic [4:0] outs = {fail_to_start, fault_mask, gen_load_out, starter_out, fuel_out};
    always #5 hclk = ~hclk;
    gms_sequencer u_dut (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
        .hrdata, .hreadyout, .hresp, .btn_stop(btn[0]), .btn_manual(btn[1]), .btn_test(btn[2]),
        .btn_auto(btn[3]), .btn_start(btn[4]), .btn_to_gen(btn[5]), .btn_to_mains(btn[6]),
        .panel_lock(lvl[0]), .mains_fail(lvl[1]), .remote_start(lvl[2]),
        .remote_start_load(lvl[3]), .aux_mains_fail(lvl[4]), .telemetry_start(lvl[5]),
        .balance_mode(lvl[6]), .load_inhibit(lvl[7]), .gen_available, .speed_alt, .speed_mpu,
        .speed_ecu, .oil_rising, .day_of_cycle(day), .fuel_out, .starter_out, .gen_load_out,
        .fault_mask, .fail_to_start, .mode_led
    );
    gms_engine_model #(.FIRE_CYC(20)) u_eng (
        .hclk, .hresetn, .fuel_out, .starter_out, .fire_en, .speed_alt, .speed_mpu,
        .speed_ecu, .oil_rising, .gen_available
    );
    task automatic complete_run();
        if (err_count == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic chkb(input logic s, input logic e);
        check({31'h0000_0000, s}, {31'h0000_0000, e});
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        htrans <= gms_pkg::HTRANS_NONSEQ;
        hwrite <= w;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0000_0000);
        check(rd, e);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge hclk);
    endtask
    task automatic press(input int i);
        btn[i] <= 1'b1;
        idle(8);
        btn[i] <= 1'b0;
        idle(8);
    endtask
    task automatic wait_out(input int i, input logic v);
        int n;
        n = 0;
        while (outs[i] !== v && n < 3000) begin
            @(posedge hclk);
            n++;
        end
        chkb(outs[i], v);
    endtask
    initial begin
        idle(2);
        hresetn <= 1'b1;
        @(posedge hclk);
        check({28'h000_0000, mode_led}, 32'h0000_0001);
        chkb(fault_mask, 1'b1);
        chkb(hresp, 1'b0);
        rd_chk(gms_pkg::ADDR_ID, gms_pkg::ID_VALUE);
        rd_chk(gms_pkg::ADDR_ATTEMPTS, {28'h000_0000, gms_pkg::ATTEMPTS_RESET});
        rd_chk(gms_pkg::ADDR_START_DLY, gms_pkg::TIMER_RESET);
        bus(1'b1, 8'h40, 32'h0000_5A5A);
        rd_chk(8'h40, 32'h0000_0000);
        for (int i = 0; i < 7; i++) begin
            bus(1'b1, 8'h0C + 8'(4 * i), tval[i]);
        end
        rd_chk(gms_pkg::ADDR_ATTEMPTS, 32'h0000_0002);
        press(1);
        check({28'h000_0000, mode_led}, 32'h0000_0002);
        press(4);
        wait_out(4, 1'b1);
        check({30'h0000_0000, outs[1:0]}, 32'h0000_0000);
        press(0);
        chkb(fail_to_start, 1'b0);
        lvl[0] <= 1'b1;
        press(2);
        check({28'h000_0000, mode_led}, 32'h0000_0001);
        lvl[0] <= 1'b0;
        fire_en <= 1'b1;
        press(1);
        press(4);
        check({30'h0000_0000, outs[1:0]}, 32'h0000_0003);
        wait_out(1, 1'b0);
        chkb(fault_mask, 1'b1);
        wait_out(3, 1'b0);
        idle(30);
        chkb(gen_load_out, 1'b0);
        press(5);
        wait_out(2, 1'b1);
        press(6);
        wait_out(2, 1'b0);
        foreach (msrc[k]) begin
            lvl[msrc[k]] <= 1'b1;
            wait_out(2, 1'b1);
            lvl[msrc[k]] <= 1'b0;
            idle(1);
            lvl[7] <= 1'b1;
            wait_out(2, 1'b0);
            idle(10);
            lvl[7] <= 1'b0;
        end
        press(0);
        check({30'h0000_0000, outs[2], outs[0]}, 32'h0000_0000);
        press(2);
        lvl[1] <= 1'b1;
        idle(100);
        chkb(fuel_out, 1'b0);
        press(4);
        wait_out(2, 1'b1);
        press(6);
        idle(20);
        chkb(gen_load_out, 1'b1);
        press(3);
        idle(120);
        check({30'h0000_0000, outs[2], outs[0]}, 32'h0000_0003);
        lvl[1] <= 1'b0;
        idle(20);
        lvl[1] <= 1'b1;
        idle(60);
        chkb(gen_load_out, 1'b1);
        lvl[1] <= 1'b0;
        wait_out(2, 1'b0);
        chkb(fuel_out, 1'b1);
        wait_out(0, 1'b0);
        lvl[2] <= 1'b1;
        idle(30);
        lvl[2] <= 1'b0;
        idle(80);
        chkb(fuel_out, 1'b0);
        foreach (asrc[k]) begin
            lvl[asrc[k]] <= 1'b1;
            idle(40);
            chkb(fuel_out, 1'b0);
            wait_out(0, 1'b1);
            wait_out(2, 1'b1);
            lvl[asrc[k]] <= 1'b0;
            wait_out(0, 1'b0);
        end
        day <= 4'h3;
        bus(1'b1, gms_pkg::ADDR_SCHED, 32'h0000_0008);
        rd_chk(gms_pkg::ADDR_SCHED, 32'h0000_0008);
        wait_out(0, 1'b1);
        day <= 4'h4;
        wait_out(0, 1'b0);
        complete_run();
    end
    initial begin
        idle(40000);
        err_count++;
        complete_run();
    end
endmodule
`default_nettype wire
